// ===== hdl/cnh_regs.vh
// Register map, field positions, reset values and timing for the node health block.
`ifndef CNH_REGS_VH
`define CNH_REGS_VH
`define CNH_OFS_CONFIG     6'h00
`define CNH_OFS_PERIOD     6'h04
`define CNH_OFS_EVT_STATUS 6'h08
`define CNH_OFS_EVT_CLEAR  6'h0c
`define CNH_OFS_EVT_ENABLE 6'h10
`define CNH_OFS_EVT_INFO   6'h14
`define CNH_OFS_EMCY_LO    6'h18
`define CNH_OFS_EMCY_HI    6'h1c
`define CNH_OFS_NODE_SEL   6'h20
`define CNH_OFS_NODE_STAT  6'h24
// Config fields: own node number and bit rate select.
`define CNH_CFG_NODE_LSB   0
`define CNH_CFG_NODE_MSB   6
`define CNH_CFG_RATE_LSB   8
`define CNH_CFG_RATE_MSB   10
`define CNH_RST_NODE       7'h01
`define CNH_RST_RATE       3'h0
`define CNH_RST_PERIOD     16'h0000
`define CNH_RST_ENABLE     6'h00
`define CNH_NODE_MAX       7'h7f
// Event bit positions in status, clear and enable.
`define CNH_EV_BUS         0
`define CNH_EV_HEALTH      1
`define CNH_EV_INPUT       2
`define CNH_EV_EMCY        3
`define CNH_EV_BOOT        4
`define CNH_EV_LOST        5
`define CNH_EV_W           6
// Received message kinds.
`define CNH_RX_HBEAT       2'h0
`define CNH_RX_GUARD       2'h1
`define CNH_RX_EMCY        2'h2
`define CNH_RX_BOOT        2'h3
// Protocol kind codes per node.
`define CNH_KIND_NONE      2'h0
`define CNH_KIND_GUARD     2'h1
`define CNH_KIND_HBEAT     2'h2
// Supervision interval unit and clock rate.
`define CNH_TICK_US        1000
`define CNH_CLK_MHZ        100
`define CNH_TICK_CYCLES    (`CNH_TICK_US * `CNH_CLK_MHZ)
`endif

// ===== hdl/cnh_node_health.v
// CANopen master network management: node supervision, liveness and host events.
`timescale 1ns/10ps
`include "cnh_regs.vh"

module cnh_node_health #(
  parameter TICK_CYCLES = `CNH_TICK_CYCLES
) (
  input  wire        sys_clk_in,
  input  wire        rstn_in,
  input  wire [5:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        rx_valid_in,
  input  wire [1:0]  rx_kind_in,
  input  wire [6:0]  rx_node_in,
  input  wire [63:0] rx_data_in,
  input  wire [1:0]  bus_state_in,
  input  wire        input_change_in,
  input  wire        lost_msg_in,
  output reg         rtr_req_out,
  output reg  [6:0]  rtr_node_out,
  input  wire        rtr_ack_in,
  output reg  [6:0]  own_node_out,
  output reg  [2:0]  bit_rate_out,
  output reg         irq_out
);

  // One-hot states of the guarding scan.
  localparam ST_IDLE = 3'b001;
  localparam ST_SEND = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg [15:0]             supervision_interval;
  reg [`CNH_EV_W-1:0]    evt_status;
  reg [`CNH_EV_W-1:0]    evt_enable;
  reg [1:0]              info_bus;
  reg [6:0]              info_node;
  reg [63:0]             emcy_data;
  reg [6:0]              node_sel;
  reg [127:1]            live;
  reg [127:1]            seen;
  reg [127:1]            kind_guard;
  reg [127:1]            kind_hbeat;
  reg [127:1]            hb_error;
  reg [1:0]              bus_prev;
  reg [31:0]             tick_cnt;
  reg [15:0]             ms_cnt;
  reg [2:0]              state;
  reg [6:0]              scan_node;
  reg [`CNH_EV_W-1:0]    next_status;
  reg [`CNH_EV_W-1:0]    ev_set;
  reg [`CNH_EV_W-1:0]    ev_clr;
  reg [31:0]             rd_mux;
  reg [127:1]            next_live;
  wire                   access;
  wire                   wr_go;
  wire                   rx_ok;
  wire                   tick;
  wire                   period_end;
  wire [127:1]           rx_hit;

  // Lowest set node of a vector, zero when none is set.
  function [6:0] cnh_first;
    input [127:1] vec;
    integer i;
    begin
      cnh_first = 7'h00;
      for (i = 127; i >= 1; i = i - 1)
        if (vec[i])
          cnh_first = i[6:0];
    end
  endfunction

  // One wait state per access; a write lands only at the edge that answers it.
  assign access     = (avs_read_in | avs_write_in) & avs_waitrequest_out;
  assign wr_go      = avs_write_in & ~avs_waitrequest_out;
  // Messages from node 0 or from ourselves are not supervised traffic.
  assign rx_ok      = rx_valid_in && (rx_node_in != 7'h00) && (rx_node_in != own_node_out);
  assign rx_hit     = rx_ok ? ({126'h0, 1'b1} << (rx_node_in - 7'h01)) : 127'h0;
  assign tick       = (tick_cnt == TICK_CYCLES - 1);
  // Interval zero disables supervision altogether.
  assign period_end = tick && (supervision_interval != 16'h0000) &&
                      (ms_cnt == supervision_interval - 16'h0001);

  // Bus slave handshake and registered read data.
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest_out <= ~access;
      if (avs_read_in & avs_waitrequest_out)
        avs_readdata_out <= rd_mux;
    end
  end

  // Read decode; unmapped and write-only offsets read zero.
  always @*
  begin
    rd_mux = 32'h00000000;
    case (avs_address_in)
      `CNH_OFS_CONFIG:     rd_mux = {21'h0, bit_rate_out, 1'b0, own_node_out};
      `CNH_OFS_PERIOD:     rd_mux = {16'h0, supervision_interval};
      `CNH_OFS_EVT_STATUS: rd_mux = {26'h0, evt_status};
      `CNH_OFS_EVT_ENABLE: rd_mux = {26'h0, evt_enable};
      `CNH_OFS_EVT_INFO:   rd_mux = {17'h0, info_node, 6'h0, info_bus};
      `CNH_OFS_EMCY_LO:    rd_mux = emcy_data[31:0];
      `CNH_OFS_EMCY_HI:    rd_mux = emcy_data[63:32];
      `CNH_OFS_NODE_SEL:   rd_mux = {25'h0, node_sel};
      `CNH_OFS_NODE_STAT:  rd_mux = (node_sel == 7'h00) ? 32'h00000000 :
                                    {28'h0, hb_error[node_sel], kind_hbeat[node_sel],
                                     kind_guard[node_sel], live[node_sel]};
      default:             rd_mux = 32'h00000000;
    endcase
  end

  // Configuration registers written by software.
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      own_node_out         <= `CNH_RST_NODE;
      bit_rate_out         <= `CNH_RST_RATE;
      supervision_interval <= `CNH_RST_PERIOD;
      evt_enable           <= `CNH_RST_ENABLE;
      node_sel             <= 7'h00;
    end
    else if (wr_go)
    begin
      case (avs_address_in)
        `CNH_OFS_CONFIG:
        begin
          // A node number of zero is outside the legal range and is ignored.
          if (avs_writedata_in[`CNH_CFG_NODE_MSB:`CNH_CFG_NODE_LSB] != 7'h00)
            own_node_out <= avs_writedata_in[`CNH_CFG_NODE_MSB:`CNH_CFG_NODE_LSB];
          bit_rate_out <= avs_writedata_in[`CNH_CFG_RATE_MSB:`CNH_CFG_RATE_LSB];
        end
        `CNH_OFS_PERIOD:     supervision_interval <= avs_writedata_in[15:0];
        `CNH_OFS_EVT_ENABLE: evt_enable <= avs_writedata_in[`CNH_EV_W-1:0];
        `CNH_OFS_NODE_SEL:   node_sel <= avs_writedata_in[6:0];
        default:             node_sel <= node_sel;
      endcase
    end
  end

  // Millisecond tick and supervision window counters.
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      tick_cnt <= 32'h00000000;
      ms_cnt   <= 16'h0000;
    end
    else
    begin
      tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
      if (supervision_interval == 16'h0000 || period_end)
        ms_cnt <= 16'h0000;
      else if (tick)
        ms_cnt <= ms_cnt + 16'h0001;
    end
  end

  // Guarding scan: one remote request per guarded or undetected node each window.
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      state        <= ST_IDLE;
      scan_node    <= 7'h01;
      rtr_req_out  <= 1'b0;
      rtr_node_out <= 7'h00;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (period_end)
          begin
            scan_node <= 7'h01;
            state     <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          // Heartbeat nodes and ourselves need no request.
          if (scan_node != own_node_out && !kind_hbeat[scan_node])
          begin
            rtr_req_out  <= 1'b1;
            rtr_node_out <= scan_node;
            state        <= ST_WAIT;
          end
          else if (scan_node == `CNH_NODE_MAX)
            state <= ST_IDLE;
          else
            scan_node <= scan_node + 7'h01;
        end
        ST_WAIT:
        begin
          if (rtr_ack_in)
          begin
            rtr_req_out <= 1'b0;
            scan_node   <= scan_node + 7'h01;
            state       <= (scan_node == `CNH_NODE_MAX) ? ST_IDLE : ST_SEND;
          end
        end
        default:
        begin
          state       <= ST_IDLE;
          rtr_req_out <= 1'b0;
        end
      endcase
    end
  end

  // Liveness after the window: seen earlier or arriving on the last cycle.
  always @*
  begin
    next_live = live;
    if (period_end)
      next_live = seen | rx_hit;
  end

  // Per-node protocol detection, replies seen, liveness and heartbeat errors.
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      live       <= 127'h0;
      seen       <= 127'h0;
      kind_guard <= 127'h0;
      kind_hbeat <= 127'h0;
      hb_error   <= 127'h0;
    end
    else
    begin
      live <= next_live;
      seen <= period_end ? 127'h0 : (seen | rx_hit);
      if (rx_ok && rx_kind_in == `CNH_RX_HBEAT)
        kind_hbeat <= kind_hbeat | rx_hit;
      if (rx_ok && rx_kind_in == `CNH_RX_GUARD)
        kind_guard <= kind_guard | rx_hit;
      if (period_end)
        hb_error <= kind_hbeat & ~(seen | rx_hit);
    end
  end

  // Event sources and their set and clear masks.
  always @*
  begin
    ev_set               = {`CNH_EV_W{1'b0}};
    ev_set[`CNH_EV_BUS]    = (bus_state_in != bus_prev);
    ev_set[`CNH_EV_HEALTH] = (next_live != live);
    ev_set[`CNH_EV_INPUT]  = input_change_in;
    ev_set[`CNH_EV_EMCY]   = rx_ok && (rx_kind_in == `CNH_RX_EMCY);
    ev_set[`CNH_EV_BOOT]   = rx_ok && (rx_kind_in == `CNH_RX_BOOT);
    ev_set[`CNH_EV_LOST]   = lost_msg_in;
    ev_clr = (wr_go && avs_address_in == `CNH_OFS_EVT_CLEAR) ?
             avs_writedata_in[`CNH_EV_W-1:0] : {`CNH_EV_W{1'b0}};
    // A new event beats a clear in the same cycle.
    next_status = (evt_status & ~ev_clr) | ev_set;
  end

  // Sticky status, event details and the interrupt line.
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      evt_status <= {`CNH_EV_W{1'b0}};
      bus_prev   <= 2'h0;
      info_bus   <= 2'h0;
      info_node  <= 7'h00;
      emcy_data  <= 64'h0;
      irq_out    <= 1'b0;
    end
    else
    begin
      evt_status <= next_status;
      bus_prev   <= bus_state_in;
      irq_out    <= |(next_status & evt_enable);
      if (ev_set[`CNH_EV_BUS])
        info_bus <= bus_state_in;
      if (ev_set[`CNH_EV_HEALTH])
        info_node <= cnh_first(next_live ^ live);
      else if (ev_set[`CNH_EV_EMCY] || ev_set[`CNH_EV_BOOT])
        info_node <= rx_node_in;
      if (ev_set[`CNH_EV_EMCY])
        emcy_data <= rx_data_in;
    end
  end

endmodule

// ===== testbench/cnh_node_health_sva.sv
// Port assertions for the node health block.
`timescale 1ns/10ps
module cnh_sva (
  input logic        sys_clk_in,
  input logic        rstn_in,
  input logic [5:0]  avs_address_in,
  input logic        avs_read_in,
  input logic        avs_write_in,
  input logic [31:0] avs_writedata_in,
  input logic        avs_waitrequest_out,
  input logic        rtr_req_out,
  input logic [6:0]  rtr_node_out,
  input logic        rtr_ack_in,
  input logic [6:0]  own_node_out,
  input logic [2:0]  bit_rate_out,
  input logic        irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // Each access gets exactly one wait state, then the bus is busy again.
  a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("access not answered");
  a_wait_back: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer held too long");
  // A remote request holds its node until acknowledged, then drops.
  a_rtr_hold: assert property (rtr_req_out && !rtr_ack_in
    |=> rtr_req_out && $stable(rtr_node_out)) else $error("request not held");
  a_rtr_drop: assert property (rtr_req_out && rtr_ack_in |=> !rtr_req_out)
    else $error("request not dropped");
  a_rtr_node: assert property (rtr_req_out |-> rtr_node_out != 7'h00
    && rtr_node_out != own_node_out) else $error("bad guarded node");
  a_own_valid: assert property (own_node_out != 7'h00)
    else $error("own node zero");
  a_cfg_write: assert property (avs_write_in && !avs_waitrequest_out
    && avs_address_in == 6'h00 && avs_writedata_in[6:0] != 7'h00
    |=> own_node_out == $past(avs_writedata_in[6:0])
    && bit_rate_out == $past(avs_writedata_in[10:8])) else $error("config not taken");
  a_rst_vals: assert property ($rose(rstn_in) |-> own_node_out == 7'h01
    && bit_rate_out == 3'h0 && !irq_out && !rtr_req_out && avs_waitrequest_out)
    else $error("bad reset values");
endmodule
bind cnh_node_health cnh_sva u_sva (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_waitrequest_out(avs_waitrequest_out), .rtr_req_out(rtr_req_out),
  .rtr_node_out(rtr_node_out), .rtr_ack_in(rtr_ack_in), .own_node_out(own_node_out),
  .bit_rate_out(bit_rate_out), .irq_out(irq_out));

// ===== testbench/cnh_slaves.sv
// Model of the slave nodes: guard acknowledgement, guard replies, heartbeats.
`timescale 1ns/10ps
module cnh_slaves #(
  parameter GUARD_NODE = 2,
  parameter HB_NODE    = 3,
  parameter HB_HALF    = 600
) (
  input  wire        clk_in,
  input  wire        hb_en_in,
  input  wire        rtr_req_in,
  input  wire [6:0]  rtr_node_in,
  output reg         rtr_ack_out,
  output reg         rx_valid_out,
  output reg  [1:0]  rx_kind_out,
  output reg  [6:0]  rx_node_out,
  output reg  [63:0] rx_data_out
);
  reg  [6:0] n;
  reg        slow;
  time       last;
  // Presents one message for a cycle, then scrambles the released lines.
  task send(input [1:0] k, input [6:0] nd, input [63:0] d);
    begin
      rx_valid_out <= 1'b1;
      rx_kind_out <= k;
      rx_node_out <= nd;
      rx_data_out <= d;
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_kind_out <= ~k;
      rx_node_out <= ~nd;
      rx_data_out <= ~d;
    end
  endtask
  // Acks alternately at once and late; one node answers guarding, one beats.
  initial
  begin
    rtr_ack_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_kind_out = 2'h0;
    rx_node_out = 7'h00;
    rx_data_out = 64'h0;
    slow = 1'b0;
    last = 0;
    forever
    begin
      @(posedge clk_in);
      if (rtr_req_in)
      begin
        n = rtr_node_in;
        if (slow)
          repeat (3) @(posedge clk_in);
        slow = !slow;
        rtr_ack_out <= 1'b1;
        @(posedge clk_in);
        rtr_ack_out <= 1'b0;
        if (n == GUARD_NODE)
          send(2'h1, n, 64'h0);
      end
      else if (hb_en_in && $time - last >= HB_HALF * 10)
      begin
        last = $time;
        send(2'h0, HB_NODE, 64'h0);
      end
    end
  end
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the node health block.
`timescale 1ns/10ps
module tb;
  logic        sys_clk_in, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic        rx_valid_in, input_change_in, lost_msg_in, rtr_req_out, rtr_ack_in;
  logic        irq_out, hb_en;
  logic [1:0]  rx_kind_in, bus_state_in;
  logic [2:0]  bit_rate_out;
  logic [5:0]  avs_address_in;
  logic [6:0]  rx_node_in, rtr_node_out, own_node_out;
  logic [31:0] avs_writedata_in, avs_readdata_out, seed, expq[$];
  logic [63:0] rx_data_in, emcy;
  integer      failures, total_checks, cycles;
  localparam integer SYNC_TICKS = 12;
  cnh_node_health #(.TICK_CYCLES(10)) dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .rx_valid_in(rx_valid_in),
    .rx_kind_in(rx_kind_in), .rx_node_in(rx_node_in), .rx_data_in(rx_data_in),
    .bus_state_in(bus_state_in), .input_change_in(input_change_in),
    .lost_msg_in(lost_msg_in), .rtr_req_out(rtr_req_out), .rtr_node_out(rtr_node_out),
    .rtr_ack_in(rtr_ack_in), .own_node_out(own_node_out), .bit_rate_out(bit_rate_out),
    .irq_out(irq_out));
  cnh_slaves m (.clk_in(sys_clk_in), .hb_en_in(hb_en), .rtr_req_in(rtr_req_out),
    .rtr_node_in(rtr_node_out), .rtr_ack_out(rtr_ack_in), .rx_valid_out(rx_valid_in),
    .rx_kind_out(rx_kind_in), .rx_node_out(rx_node_in), .rx_data_out(rx_data_in));
  // Free running 100 MHz clock.
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task tick(input integer k);
    repeat (k) @(posedge sys_clk_in);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One bus access, held until waitrequest is sampled low.
  task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e);
    expq.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask
  task pulse_lost;
    lost_msg_in <= 1'b1;
    tick(1);
    lost_msg_in <= 1'b0;
  endtask
  // Compares read data with the oldest note and cuts a hang short.
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (avs_read_in && avs_waitrequest_out === 1'b0)
      chk(avs_readdata_out, expq.pop_front());
    if (cycles > 30000)
    begin
      failures++;
      summarize;
    end
  end
  initial
  begin
    {failures, total_checks, cycles} = 0;
    {rstn_in, avs_read_in, avs_write_in, hb_en, input_change_in, lost_msg_in} = 0;
    {avs_address_in, avs_writedata_in, bus_state_in} = 0;
    seed = 32'h1aa78691;
    tick(10);
    rstn_in <= 1'b1;
    tick(1);
    rd(6'h00, 32'h1);
    rd(6'h04, 32'h0);
    rd(6'h08, 32'h0);
    rd(6'h0c, 32'h0);
    rd(6'h28, 32'h0);
    acc(1'b1, 6'h00, 32'h555);
    rd(6'h00, 32'h555);
    acc(1'b1, 6'h00, 32'h300);
    rd(6'h00, 32'h355);
    acc(1'b1, 6'h10, 32'h3f);
    // Every event source except health in turn, plus a boot message from our own number.
    input_change_in <= 1'b1;
    tick(1);
    input_change_in <= 1'b0;
    pulse_lost();
    bus_state_in <= 2'h2;
    seed = lfsr(seed);
    emcy[31:0] = seed;
    seed = lfsr(seed);
    emcy[63:32] = seed;
    m.send(2'h2, 7'h05, emcy);
    tick(1);
    m.send(2'h3, 7'h55, 64'h0);
    tick(1);
    chk(irq_out, 1'b1);
    rd(6'h08, 32'h2d);
    rd(6'h14, 32'h502);
    rd(6'h18, emcy[31:0]);
    rd(6'h1c, emcy[63:32]);
    m.send(2'h3, 7'h06, 64'h0);
    rd(6'h08, 32'h3d);
    // A masked event stays pending until its enable bit is set.
    acc(1'b1, 6'h0c, 32'h3f);
    acc(1'b1, 6'h10, 32'h04);
    pulse_lost();
    tick(2);
    chk(irq_out, 1'b0);
    rd(6'h08, 32'h20);
    acc(1'b1, 6'h10, 32'h20);
    tick(1);
    chk(irq_out, 1'b1);
    acc(1'b1, 6'h0c, 32'h3f);
    tick(1);
    chk(irq_out, 1'b0);
    // Supervision: node 2 guarded, node 3 beating, then node 3 falls silent.
    acc(1'b1, 6'h10, 32'h02);
    hb_en <= 1'b1;
    acc(1'b1, 6'h04, 10 * SYNC_TICKS);
    tick(4800);
    acc(1'b1, 6'h20, 32'h2);
    rd(6'h24, 32'h3);
    acc(1'b1, 6'h20, 32'h3);
    rd(6'h24, 32'h5);
    hb_en <= 1'b0;
    tick(3600);
    acc(1'b1, 6'h20, 32'h3);
    rd(6'h24, 32'hc);
    rd(6'h08, 32'h2);
    chk(irq_out, 1'b1);
    summarize;
  end
endmodule
